// ===== design/adc_sampling_clock_control.sv
`timescale 1ns/1ps
`default_nettype none
module adc_sampling_clock_control
   import adc_clk_ctl_pkg::*;
#(
   parameter int N_TIMER_TRIG = 3             // timer trigger inputs
) (
   // core clock and reset
   input  wire logic              core_clk_in,
   input  wire logic              arst_n_in,
   // avalon-mm slave
   // one wait state on every access, no bursts
   input  wire logic [ADDR_W-1:0] avs_address_in,
   input  wire logic              avs_read_in,
   input  wire logic              avs_write_in,
   input  wire logic [DATA_W-1:0] avs_writedata_in,
   input  wire logic [3:0]        avs_byteenable_in,
   output logic [DATA_W-1:0]      avs_readdata_out,
   output logic                   avs_waitrequest_out,
   // trigger and clock sources
   // levels, taken as synchronous to core_clk_in
   input  wire logic [N_TIMER_TRIG-1:0] timer_trigger_in,
   input  wire logic              sampling_timer_in,
   input  wire logic              module_oscillator_clock_in,
   input  wire logic              aux_clock_in,
   input  wire logic              subsystem_master_clock_in,
   input  wire logic              converter_active_in,
   // toward the converter
   // every output here leaves a flop
   output logic                   sample_input_out,
   output logic                   sampling_window_signal_out,
   output logic                   converter_clock_out,
   output logic [1:0]             sequence_mode_select_out,
   output logic                   conversion_enable_bit_out
);

   ////////////////////////////////////////////////////////////////////
   // elaboration checks
   // refused before any cycle runs; the trigger mux
   // below is written out for exactly three timers,
   // and a wider set would need a wider field as well
   if (N_TIMER_TRIG != 3) begin : g_bad_trig
      $error("exactly three timer triggers are supported");
   end

   ////////////////////////////////////////////////////////////////////
   // configuration state
   // all fields reset to zero and sit in plain flops,
   // so a rewrite reaches the datapath next cycle
   logic [1:0] sample_trigger_source;         // sample input select
   logic       sample_pulse_mode;             // window source
   logic       sample_input_invert;           // sample polarity
   logic [2:0] conv_clock_divider;            // divide minus one
   logic [1:0] conv_clock_source;             // clock mux select
   logic [1:0] sequence_mode_select;          // conversion pattern
   logic       conversion_enable_bit;         // locks the fields
   logic       software_start_bit;            // self clearing start
   logic       converter_busy_flag;           // registered busy

   // bus handshake state
   logic              ack;                    // answer cycle flag
   logic [DATA_W-1:0] rdata;                  // registered read data

   // output registers
   logic sample_q;                            // registered sample input
   logic window_q;                            // registered window

   ////////////////////////////////////////////////////////////////////
   // bus decode
   // handshake in short:
   //   cycle 0: request seen, waitrequest high
   //   cycle 1: waitrequest low, write lands at its end
   //   cycle 2: master free for the next request
   //   a new request may follow with no idle cycle
   // read data are loaded at the end of cycle 0, so
   // they stand for the whole of cycle 1
   wire req        = avs_read_in | avs_write_in;
   // the one wait cycle gives the read mux a full period
   wire wait_req   = req & ~ack;
   wire wr_take    = avs_write_in & ack;      // write lands here
   wire hit_sample = (avs_address_in == OFF_SAMPLE_CTL);
   wire hit_run    = (avs_address_in == OFF_RUN_CTL);
   wire be_lo      = avs_byteenable_in[0];    // bits 7..0
   wire be_hi      = avs_byteenable_in[1];    // bits 15..8

   // lanes 2 and 3 carry nothing; a write with neither
   // low lane set is a silent no-op

   // field writes pass only while conversions are disabled
   // a locked write is dropped with no error status, so
   // software must clear enable first and then rewrite
   wire cfg_open   = ~conversion_enable_bit;
   wire wr_cfg_lo  = wr_take & hit_sample & be_lo & cfg_open;
   wire wr_cfg_hi  = wr_take & hit_sample & be_hi & cfg_open;
   wire wr_run     = wr_take & hit_run & be_lo;

   // new enable value and start request from the run word
   wire wr_enable  = avs_writedata_in[POS_ENABLE];
   wire wr_start   = avs_writedata_in[POS_START];

   ////////////////////////////////////////////////////////////////////
   // read mux
   // reserved upper nibble and upper half word stay zero
   // the run word holds two bits; the rest of it and
   // every unmapped word read zero
   wire [CTL_W-1:0] sample_word = {
      4'h0,
      sample_trigger_source,
      sample_pulse_mode,
      sample_input_invert,
      conv_clock_divider,
      conv_clock_source,
      sequence_mode_select,
      converter_busy_flag
   };
   wire [DATA_W-1:0] run_word = {
      30'h0,
      conversion_enable_bit,
      software_start_bit
   };
   wire [DATA_W-1:0] read_mux =
      hit_sample ? {16'h0, sample_word} :
      hit_run    ? run_word             :
                   32'h0;               // unmapped reads zero

   ////////////////////////////////////////////////////////////////////
   // handshake: one wait cycle, then answer
   // ack never stays high two cycles running, so a held
   // request cannot be answered twice
   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         ack <= 1'b0;
      end else begin
         ack <= wait_req;                     // pulse for one cycle
      end
   end

   // read data registered on the cycle before the answer
   // loaded once per read; it holds until the next read,
   // so a late look still sees the same word
   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         rdata <= 32'h0;
      end else if (avs_read_in & ~ack) begin
         rdata <= read_mux;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // high byte: trigger source, pulse mode, invert
   // bits 15..12 have no storage, writes there vanish
   // lane 1 alone updates this byte, so lane 0 may carry
   // a divider change in the same write or not at all
   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         sample_trigger_source <= RST_TRIG;
         sample_pulse_mode     <= RST_PULSE;
         sample_input_invert   <= RST_INVERT;
      end else if (wr_cfg_hi) begin
         sample_trigger_source <=
            avs_writedata_in[POS_TRIG_LSB +: 2];
         sample_pulse_mode     <= avs_writedata_in[POS_PULSE];
         sample_input_invert   <= avs_writedata_in[POS_INVERT];
      end
   end

   // low byte: divider, clock source, sequence mode
   // busy bit 0 has no storage behind the bus
   // writing bit 0 is harmless: the busy flag has its own
   // process and never listens to the bus
   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         conv_clock_divider   <= RST_DIV;
         conv_clock_source    <= RST_CSRC;
         sequence_mode_select <= RST_SEQ;
      end else if (wr_cfg_lo) begin
         conv_clock_divider   <=
            avs_writedata_in[POS_DIV_LSB +: 3];
         conv_clock_source    <=
            avs_writedata_in[POS_CSRC_LSB +: 2];
         sequence_mode_select <=
            avs_writedata_in[POS_SEQ_LSB +: 2];
      end
   end

   ////////////////////////////////////////////////////////////////////
   // run control: enable and software start
   // enable itself is never locked, or software could
   // not leave the locked state again
   // a run write lands with the timing of a field write
   // a start is taken on the cycle it is seen with enable high
   wire start_taken = software_start_bit & conversion_enable_bit;
   // start may ride the same write that sets enable
   wire start_set   = wr_run & wr_start & wr_enable;

   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         conversion_enable_bit <= RST_ENABLE;
      end else if (wr_run) begin
         // clearing enable reopens the fields next cycle,
         // no wait for a conversion in flight
         conversion_enable_bit <= wr_enable;
      end
   end

   // set wins over the automatic clear
   // a start left pending with enable low would fire
   // later unasked, so dropping enable drops it too
   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         software_start_bit <= RST_START;
      end else if (start_set) begin
         software_start_bit <= 1'b1;
      end else if (start_taken | ~conversion_enable_bit) begin
         software_start_bit <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // sample input selection and polarity
   // timer triggers are taken as already synchronous;
   // one from another clock domain must be synchronised
   // before it reaches this block
   // the software start feeds the mux as the taken
   // pulse, so it reaches the sample input for one cycle
   // fields drive the mux straight from storage, so a
   // rewrite acts on the very next cycle
   wire trig_raw =
      (sample_trigger_source == TRIG_SOFT) ? start_taken :
      (sample_trigger_source == TRIG_TMR0) ? timer_trigger_in[0] :
      (sample_trigger_source == TRIG_TMR1) ? timer_trigger_in[1] :
                                             timer_trigger_in[2];
   wire sample_input = trig_raw ^ sample_input_invert;

   // window: direct sample input or the sampling timer
   // in pulse mode the sampling timer owns the window and
   // the sample input only serves to start that timer
   wire window_next  = sample_pulse_mode ? sampling_timer_in
                                         : sample_input;

   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         sample_q <= 1'b0;
         window_q <= 1'b0;
      end else begin
         sample_q <= sample_input;
         window_q <= window_next;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // busy: window open or converter still working
   // limitation: relies on converter_active_in for the
   // sequence and conversion part of the operation
   // busy lags the window by one more cycle, so a read
   // right after a start may still show the block idle
   wire busy_next = window_q | converter_active_in;

   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         converter_busy_flag <= 1'b0;
      end else begin
         converter_busy_flag <= busy_next;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // converter clock: source mux, then divider
   // sources are slow levels sampled on the core clock, so
   // each must stay below half the core rate
   // a source swap can cut or stretch one divided period,
   // as the edge detect sees the new level at once
   // the divided clock is a one-cycle pulse, not a real
   // clock: the converter stays on the core clock and
   // counts each pulse as one converter clock period
   wire clk_src_level =
      (conv_clock_source == CSRC_OSC) ? module_oscillator_clock_in :
      (conv_clock_source == CSRC_AUX) ? aux_clock_in :
                                        subsystem_master_clock_in;

   adc_clock_divider #(
      .W            (DIV_W)
   ) u_div (
      .core_clk_in  (core_clk_in),
      .arst_n_in    (arst_n_in),
      .src_level_in (clk_src_level),
      .div_in       (conv_clock_divider),
      .tick_out     (converter_clock_out)
   );

   ////////////////////////////////////////////////////////////////////
   // outputs
   // waitrequest is the one output not taken from a flop,
   // so the master sees the wait state in cycle 0
   assign avs_waitrequest_out        = wait_req;
   assign avs_readdata_out           = rdata;
   assign sample_input_out           = sample_q;
   assign sampling_window_signal_out = window_q;
   assign sequence_mode_select_out   = sequence_mode_select;
   assign conversion_enable_bit_out  = conversion_enable_bit;

endmodule
`default_nettype wire

// ===== design/adc_clk_ctl_pkg.sv
`default_nettype none
package adc_clk_ctl_pkg;

   // bus geometry
   localparam int ADDR_W      = 4;       // byte address bits
   localparam int DATA_W      = 32;      // avalon data width
   localparam int CTL_W       = 16;      // control register width

   // register byte offsets, one aligned word each
   localparam logic [ADDR_W-1:0] OFF_SAMPLE_CTL = 4'h0;
   localparam logic [ADDR_W-1:0] OFF_RUN_CTL    = 4'h4;

   // sampling_clock_sequence_control field positions
   localparam int POS_TRIG_LSB = 10;     // sample_trigger_source
   localparam int POS_PULSE    = 9;      // sample_pulse_mode
   localparam int POS_INVERT   = 8;      // sample_input_invert
   localparam int POS_DIV_LSB  = 5;      // conv_clock_divider
   localparam int POS_CSRC_LSB = 3;      // conv_clock_source
   localparam int POS_SEQ_LSB  = 1;      // sequence_mode_select
   localparam int POS_BUSY     = 0;      // converter_busy_flag

   // run control word field positions
   localparam int POS_START    = 0;      // software_start_bit
   localparam int POS_ENABLE   = 1;      // conversion_enable_bit

   // reset values, all fields clear
   localparam logic [1:0] RST_TRIG   = 2'h0;
   localparam logic       RST_PULSE  = 1'h0;
   localparam logic       RST_INVERT = 1'h0;
   localparam logic [2:0] RST_DIV    = 3'h0;
   localparam logic [1:0] RST_CSRC   = 2'h0;
   localparam logic [1:0] RST_SEQ    = 2'h0;
   localparam logic       RST_ENABLE = 1'h0;
   localparam logic       RST_START  = 1'h0;

   // trigger source encodings
   localparam logic [1:0] TRIG_SOFT  = 2'h0;
   localparam logic [1:0] TRIG_TMR0  = 2'h1;
   localparam logic [1:0] TRIG_TMR1  = 2'h2;
   localparam logic [1:0] TRIG_TMR2  = 2'h3;

   // clock source encodings, both upper codes give master
   localparam logic [1:0] CSRC_OSC   = 2'h0;
   localparam logic [1:0] CSRC_AUX   = 2'h1;

   // sequence modes
   localparam logic [1:0] SEQ_SINGLE     = 2'h0;
   localparam logic [1:0] SEQ_SEQUENCE   = 2'h1;
   localparam logic [1:0] SEQ_REPEAT_ONE = 2'h2;
   localparam logic [1:0] SEQ_REPEAT_SEQ = 2'h3;

   // divider width
   localparam int DIV_W = 3;

endpackage
`default_nettype wire

// ===== design/adc_clock_divider.sv
`timescale 1ns/1ps
`default_nettype none
module adc_clock_divider
   import adc_clk_ctl_pkg::*;
#(
   parameter int W = DIV_W                  // divider field width
) (
   input  wire logic         core_clk_in,   // core clock
   input  wire logic         arst_n_in,     // async reset, low
   input  wire logic         src_level_in,  // selected source level
   input  wire logic [W-1:0] div_in,        // divide by value plus one
   output logic              tick_out       // one pulse per period
);

   // refused at elaboration
   if (W < 1 || W > 8) begin : g_bad_width
      $error("divider width out of range");
   end

   logic         src_q;                     // previous source level
   logic [W-1:0] count;                     // source edges seen
   logic         tick;                      // divided clock pulse
   wire          src_rise = src_level_in & ~src_q;
   // a shrunken divider must not strand the count above it
   wire          wrap     = (count >= div_in);

   ////////////////////////////////////////////////////////////////////
   // edge detect on the selected source
   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         src_q <= 1'b0;
      end else begin
         src_q <= src_level_in;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // count source edges, emit one tick per div_in+1 edges
   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         count <= '0;
         tick  <= 1'b0;
      end else begin
         tick <= src_rise & wrap;
         if (src_rise) begin
            count <= wrap ? '0 : count + W'(1);
         end
      end
   end

   assign tick_out = tick;

endmodule
`default_nettype wire

// ===== verification/adc_sampling_clock_control_props.sv
`timescale 1ns/1ps
`default_nettype none
module adc_sampling_clock_control_props
   import adc_clk_ctl_pkg::*;
#(
   parameter int N_TIMER_TRIG = 3             // timer trigger inputs
) (
   input wire logic                    core_clk_in,
   input wire logic                    arst_n_in,
   input wire logic [ADDR_W-1:0]       avs_address_in,
   input wire logic                    avs_read_in,
   input wire logic                    avs_write_in,
   input wire logic [DATA_W-1:0]       avs_writedata_in,
   input wire logic [3:0]              avs_byteenable_in,
   input wire logic [DATA_W-1:0]       avs_readdata_out,
   input wire logic                    avs_waitrequest_out,
   input wire logic [N_TIMER_TRIG-1:0] timer_trigger_in,
   input wire logic                    sampling_timer_in,
   input wire logic                    converter_active_in,
   input wire logic                    sample_input_out,
   input wire logic                    sampling_window_signal_out,
   input wire logic                    converter_clock_out,
   input wire logic [1:0]              sequence_mode_select_out,
   input wire logic                    conversion_enable_bit_out
);
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!arst_n_in);
   ////////////////////////////////////////////////////////////////////////
   // bus decode seen from outside
   wire req = avs_read_in | avs_write_in;             // request pending
   wire ack = req & ~avs_waitrequest_out;              // answer cycle
   wire on0 = avs_address_in == OFF_SAMPLE_CTL;        // field register
   wire wr0 = ack & avs_write_in & on0;                // field write lands
   wire rd0 = ack & avs_read_in & on0;                 // field read answer
   wire wr4 = ack & avs_write_in & avs_byteenable_in[0]
            & (avs_address_in == OFF_RUN_CTL);         // run write lands
   logic [3:0] fld;                                    // trig, pulse, invert
   // mirror of the upper lane fields; locked like the real one
   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         fld <= 4'h0;
      end else if (wr0 && !conversion_enable_bit_out
                   && avs_byteenable_in[1]) begin
         fld <= avs_writedata_in[11:8];
      end
   end
   // only meaningful for timer codes; code 0 would index past the top
   wire sel_trig = timer_trigger_in[fld[3:2] - 2'h1];
   ////////////////////////////////////////////////////////////////////////
   sequence s_active_held;
      converter_active_in [*4];
   endsequence
   sequence s_idle_held;
      (!converter_active_in && !sampling_window_signal_out) [*4];
   endsequence
   sequence s_soft_start;
      wr4 && avs_writedata_in[1:0] == 2'h3 && fld == 4'h0;
   endsequence
   a_wait_one_cycle: assert property (req && avs_waitrequest_out
      |=> !avs_waitrequest_out) else $error("wait state too long");
   a_field_lock: assert property (
      wr0 && conversion_enable_bit_out |=> $stable(sequence_mode_select_out))
      else $error("field changed while enabled");
   a_seq_update: assert property (
      wr0 && !conversion_enable_bit_out && avs_byteenable_in[0]
      |=> sequence_mode_select_out == $past(avs_writedata_in[2:1]))
      else $error("sequence mode not taken at once");
   a_reserved_zero: assert property (
      rd0 |-> avs_readdata_out[15:12] == 4'h0)
      else $error("reserved bits not zero");
   a_busy_set: assert property (
      s_active_held ##1 rd0 |-> avs_readdata_out[POS_BUSY])
      else $error("busy low while active");
   a_busy_clear: assert property (
      s_idle_held ##1 rd0 |-> !avs_readdata_out[POS_BUSY])
      else $error("busy high while idle");
   a_sample_timer: assert property (
      fld[3:2] != 2'h0 && fld == $past(fld)
      |-> sample_input_out == ($past(sel_trig) ^ fld[0]))
      else $error("sample input not selected timer");
   a_window_timer: assert property (
      fld[1] && $past(fld[1])
      |-> sampling_window_signal_out == $past(sampling_timer_in))
      else $error("window not from sampling timer");
   a_start_pulse: assert property (
      s_soft_start |-> ##2 sample_input_out ##1 !sample_input_out)
      else $error("software start pulse wrong");
   a_tick_single: assert property (
      converter_clock_out |=> !converter_clock_out)
      else $error("converter clock pulse too long");
endmodule
bind adc_sampling_clock_control adc_sampling_clock_control_props
   #(.N_TIMER_TRIG(N_TIMER_TRIG)) i_props (.*);
`default_nettype wire

// ===== verification/adc_sampling_clock_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
module adc_sampling_clock_control_tb;
   import adc_clk_ctl_pkg::*;
   logic core_clk_in, arst_n_in, avs_read_in, avs_write_in;
   logic [ADDR_W-1:0] avs_address_in;
   logic [DATA_W-1:0] avs_writedata_in, avs_readdata_out;
   logic [3:0]        avs_byteenable_in;      // all lanes, one lane test
   logic avs_waitrequest_out, sampling_timer_in, converter_active_in;
   logic [2:0] timer_trigger_in;
   logic module_oscillator_clock_in, aux_clock_in, subsystem_master_clock_in;
   logic sample_input_out, sampling_window_signal_out, converter_clock_out;
   logic conversion_enable_bit_out;
   logic [1:0] sequence_mode_select_out;
   int miscompares = 0;
   int n_tests = 0;
   int cyc = 0;                               // free cycle count
   adc_sampling_clock_control i_adc_sampling_clock_control (.*);
   ////////////////////////////////////////////////////////////////////////
   initial begin
      core_clk_in = 1'b0;
      forever #2.5 core_clk_in = ~core_clk_in;
   end
   // slow sources, periods 4, 6 and 10 core cycles
   always @(posedge core_clk_in) begin
      cyc <= cyc + 1;
      module_oscillator_clock_in <= (cyc % 4) < 2;
      aux_clock_in <= (cyc % 6) < 3;
      subsystem_master_clock_in <= (cyc % 10) < 5;
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic give_verdict;
      $display("comparisons %0d miscompares %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   // one bus cycle; held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [3:0] a,
                      input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      avs_address_in <= a;
      avs_writedata_in <= d;
      avs_write_in <= wr;
      avs_read_in <= !wr;
      do begin
         @(posedge core_clk_in);
         n++;
      end while (avs_waitrequest_out !== 1'b0);
      q = avs_readdata_out;
      chk(32'(n), 32'h2);                     // one wait state each
      avs_write_in <= 1'b0;
      avs_read_in <= 1'b0;
      // idle edge so a strobe is never driven twice in one step
      @(posedge core_clk_in);
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      chk(q, e);
   endtask
   // cycles until the next converter clock pulse
   task automatic next_tick(output int n);
      n = 0;
      do begin
         @(posedge core_clk_in);
         n++;
      end while (converter_clock_out !== 1'b1 && n < 300);
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      int g;
      int per[4] = '{4, 6, 10, 10};           // source period by code
      arst_n_in = 1'b0;
      {avs_read_in, avs_write_in, avs_address_in, avs_writedata_in} = '0;
      avs_byteenable_in = 4'hF;
      {timer_trigger_in, sampling_timer_in, converter_active_in} = '0;
      {module_oscillator_clock_in, aux_clock_in} = '0;
      subsystem_master_clock_in = 1'b0;
      repeat (6) @(posedge core_clk_in);
      arst_n_in <= 1'b1;
      @(posedge core_clk_in);
      rd(OFF_SAMPLE_CTL, 32'h0);
      rd(OFF_RUN_CTL, 32'h0);
      rd(4'h8, 32'h0);
      wr(OFF_SAMPLE_CTL, 32'hFFFF_FFFF);
      rd(OFF_SAMPLE_CTL, 32'h0000_0FFE);
      // upper lane alone clears trigger, pulse and invert
      avs_byteenable_in <= 4'h2;
      wr(OFF_SAMPLE_CTL, 32'h0000_0000);
      rd(OFF_SAMPLE_CTL, 32'h0000_00FE);
      avs_byteenable_in <= 4'hF;
      for (int m = 0; m < 4; m++) begin
         wr(OFF_SAMPLE_CTL, 32'(m) << POS_SEQ_LSB);
         chk(32'(sequence_mode_select_out), 32'(m));
      end
      // each timer trigger, both polarities, selected high then low
      for (int t = 1; t < 4; t++) begin
         for (int v = 0; v < 2; v++) begin
            wr(OFF_SAMPLE_CTL, 32'((t << 10) | (v << 8)));
            timer_trigger_in <= 3'(1 << (t - 1));
            repeat (3) @(posedge core_clk_in);
            chk(32'(sample_input_out), 32'(1 ^ v));
            timer_trigger_in <= ~3'(1 << (t - 1));
            repeat (3) @(posedge core_clk_in);
            chk(32'(sample_input_out), 32'(v));
         end
      end
      timer_trigger_in <= 3'h0;
      // window from timer, then from the sample input
      wr(OFF_SAMPLE_CTL, 32'h0200);
      sampling_timer_in <= 1'b1;
      repeat (3) @(posedge core_clk_in);
      chk(32'(sampling_window_signal_out), 32'h1);
      wr(OFF_SAMPLE_CTL, 32'h0000);
      repeat (3) @(posedge core_clk_in);
      chk(32'(sampling_window_signal_out), 32'h0);
      wr(OFF_SAMPLE_CTL, 32'h0100);
      sampling_timer_in <= 1'b0;
      repeat (3) @(posedge core_clk_in);
      chk(32'(sampling_window_signal_out), 32'h1);
      rd(OFF_SAMPLE_CTL, 32'h0101);
      wr(OFF_SAMPLE_CTL, 32'h0000);
      converter_active_in <= 1'b1;
      repeat (4) @(posedge core_clk_in);
      rd(OFF_SAMPLE_CTL, 32'h0001);
      converter_active_in <= 1'b0;
      repeat (4) @(posedge core_clk_in);
      rd(OFF_SAMPLE_CTL, 32'h0000);
      // every source code at both ends of the divider
      for (int s = 0; s < 4; s++) begin
         for (int d = 0; d < 8; d += 7) begin
            wr(OFF_SAMPLE_CTL, 32'((d << POS_DIV_LSB) | (s << POS_CSRC_LSB)));
            next_tick(g);
            next_tick(g);
            next_tick(g);
            chk(32'(g), 32'(per[s] * (d + 1)));
         end
      end
      // locked while enabled; rewrite after disable acts at once
      wr(OFF_SAMPLE_CTL, 32'h0002);
      wr(OFF_RUN_CTL, 32'h2);
      wr(OFF_SAMPLE_CTL, 32'h0006);
      rd(OFF_SAMPLE_CTL, 32'h0002);
      chk(32'(sequence_mode_select_out), 32'h1);
      converter_active_in <= 1'b1;
      wr(OFF_RUN_CTL, 32'h0);
      wr(OFF_SAMPLE_CTL, 32'h0006);
      chk(32'(sequence_mode_select_out), 32'h3);
      rd(OFF_SAMPLE_CTL, 32'h0007);
      converter_active_in <= 1'b0;
      // start set together with enable, then cleared by itself
      wr(OFF_SAMPLE_CTL, 32'h0000);
      wr(OFF_RUN_CTL, 32'h3);
      @(posedge core_clk_in);
      chk(32'(sample_input_out), 32'h1);
      rd(OFF_RUN_CTL, 32'h2);
      chk(32'(conversion_enable_bit_out), 32'h1);
      wr(OFF_RUN_CTL, 32'h0);
      give_verdict;
   end
   // hang guard, well past the thousand or so cycles the tests need
   initial begin
      repeat (20000) @(posedge core_clk_in);
      miscompares++;
      give_verdict;
   end
endmodule
`default_nettype wire
